// >>> ipv_arbiter.sv
`timescale 1ns/10ps
`include "ipv_consts.svh"
module ipv_arbiter
  import ipv_pkg::*;
(
  input wire logic [`IPV_NUM_SRC-1:0] cand,
  input wire ipv_level_t cand_level [`IPV_NUM_SRC],
  input wire ipv_vec_t cand_vec [`IPV_NUM_SRC],
  output logic best_valid,
  output ipv_level_t best_level,
  output ipv_vec_t best_vec
);
  // Candidates are ordered by vector, so scanning downward with >=
  // leaves the lowest vector of equal level as the winner
  always_comb begin
    best_valid = 1'b0;
    best_level = 4'h0;
    best_vec = 7'h00;
    for (int i = `IPV_NUM_SRC - 1; i >= 0; i--) begin
      if (cand[i] && (!best_valid || cand_level[i] >= best_level)) begin
        best_valid = 1'b1;
        best_level = cand_level[i];
        best_vec = cand_vec[i];
      end
    end
  end
endmodule

// >>> ipv_consts.svh
`ifndef IPV_CONSTS_SVH
`define IPV_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define IPV_OFS_PRIO_A 4'h0
`define IPV_OFS_PRIO_B 4'h1
`define IPV_OFS_STATUS 4'h2
`define IPV_OFS_CTRL1 4'h3
`define IPV_OFS_FLAGS 4'h4
`define IPV_OFS_ENABLES 4'h5
`define IPV_OFS_CPU_LEVEL 4'h6

// ****************************************
// Field layout
// ****************************************
`define IPV_NUM_USER 7
`define IPV_NUM_TRAP 4
`define IPV_NUM_SRC 11
`define IPV_REG_A_FIELDS 3
`define IPV_REG_A_TOP_LSB 8
`define IPV_REG_B_TOP_LSB 12
`define IPV_FIELD_STRIDE 4
`define IPV_PRIO_A_MASK 16'h0777
`define IPV_PRIO_B_MASK 16'h7777
`define IPV_STAT_LEVEL_LSB 8
`define IPV_STAT_VEC_LSB 0
`define IPV_NEST_DIS_BIT 15
`define IPV_TRAP_FLAG_LSB 0

// ****************************************
// Reset values, levels, vector base and sizes
// ****************************************
`define IPV_PRIO_RESET 3'h4
`define IPV_PRIO_OFF 3'h0
`define IPV_TIMED_CEIL 4'h7
`define IPV_TRAP_BASE_LEVEL 4'h8
`define IPV_VEC_USER_BASE 7'h10
`define IPV_STACK_DEPTH 4
`define IPV_STACK_PTR_W 3
`define IPV_TIMER_W 14

`endif

// >>> ipv_controller.sv
`timescale 1ns/10ps
`include "ipv_consts.svh"

module ipv_controller
  import ipv_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [`IPV_NUM_USER-1:0] src_event,
  input wire logic [`IPV_NUM_TRAP-1:0] trap_event,
  output logic irq_req,
  output ipv_level_t irq_level,
  output ipv_vec_t irq_vector_index,
  input wire logic irq_ack,
  input wire logic [15:0] ack_pc,
  input wire logic [7:0] ack_srl,
  input wire logic return_from_interrupt_op,
  output logic [15:0] ret_pc,
  output logic [7:0] ret_srl,
  output logic ret_valid,
  output ipv_level_t cpu_level,
  input wire logic timed_interrupt_block_op,
  input wire logic [`IPV_TIMER_W-1:0] timed_block_cycles,
  output logic timed_block_active
);
  // ****************************************
  // Declarations
  // ****************************************
  ipv_prio_t user_prio [`IPV_NUM_USER];
  logic [`IPV_NUM_USER-1:0] source_flag_regs;
  logic [`IPV_NUM_USER-1:0] source_enable_regs;
  logic [`IPV_NUM_TRAP-1:0] trap_flag;
  logic nesting_disable;
  logic [`IPV_TIMER_W-1:0] timed_count;
  logic [`IPV_NUM_SRC-1:0] cand;
  ipv_level_t cand_level [`IPV_NUM_SRC];
  ipv_vec_t cand_vec [`IPV_NUM_SRC];
  logic best_valid;
  ipv_level_t best_level;
  ipv_vec_t best_vec;
  ipv_frame_t top_frame;
  logic stack_empty;
  logic stack_full;
  logic nest_block;
  logic do_pop;
  logic take_vec;
  logic next_req;
  logic wr_a;
  logic wr_b;
  logic wr_ctrl;
  logic wr_flags;
  logic [15:0] uart_error_fault_priority;
  logic [15:0] can_tx_dma_priority;
  logic [15:0] interrupt_level_vector_status;
  logic [15:0] interrupt_control_one;
  logic [15:0] next_rdata;

  assign wr_a = reg_wr && reg_addr == `IPV_OFS_PRIO_A;
  assign wr_b = reg_wr && reg_addr == `IPV_OFS_PRIO_B;
  assign wr_ctrl = reg_wr && reg_addr == `IPV_OFS_CTRL1;
  assign wr_flags = reg_wr && reg_addr == `IPV_OFS_FLAGS;
  assign timed_block_active = (timed_count != '0);
  // Acknowledge has priority; a return in the same cycle is dropped
  assign do_pop = return_from_interrupt_op && !irq_ack && !stack_empty;
  assign take_vec = irq_ack && irq_req;

  // ****************************************
  // Priority fields and user source request terms
  // ****************************************
  for (genvar g = 0; g < `IPV_NUM_USER; g++) begin : g_user
    localparam bit IN_A = (g < `IPV_REG_A_FIELDS);
    localparam int LSB = IN_A ?
      (`IPV_REG_A_TOP_LSB - `IPV_FIELD_STRIDE * g) :
      (`IPV_REG_B_TOP_LSB - `IPV_FIELD_STRIDE * (g - `IPV_REG_A_FIELDS));
    logic fld_wr;
    logic user_ok;
    assign fld_wr = IN_A ? wr_a : wr_b;

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        user_prio[g] <= `IPV_PRIO_RESET;
      end else if (fld_wr) begin
        user_prio[g] <= reg_wdata[LSB +: 3];
      end
    end

    // Timed block spares level 7 and traps; nesting lock spares traps only
    assign user_ok = source_enable_regs[g] && source_flag_regs[g]
      && user_prio[g] != `IPV_PRIO_OFF
      && !(timed_block_active && {1'b0, user_prio[g]} < `IPV_TIMED_CEIL)
      && !nest_block;
    assign cand[`IPV_NUM_TRAP + g] = user_ok
      && {1'b0, user_prio[g]} > cpu_level;
    assign cand_level[`IPV_NUM_TRAP + g] = {1'b0, user_prio[g]};
    assign cand_vec[`IPV_NUM_TRAP + g] = `IPV_VEC_USER_BASE + 7'(g);
  end

  // ****************************************
  // Trap request terms
  // ****************************************
  for (genvar t = 0; t < `IPV_NUM_TRAP; t++) begin : g_trap
    // No mask term here: traps bypass enable, timed block and nesting lock
    assign cand[t] = trap_flag[t]
      && (`IPV_TRAP_BASE_LEVEL + 4'(t)) > cpu_level;
    assign cand_level[t] = `IPV_TRAP_BASE_LEVEL + 4'(t);
    assign cand_vec[t] = 7'(t);
  end

  assign nest_block = nesting_disable && !stack_empty;

  // Candidate order follows vector number, which the tie rule uses
  ipv_arbiter u_arbiter (
    .cand(cand),
    .cand_level(cand_level),
    .cand_vec(cand_vec),
    .best_valid(best_valid),
    .best_level(best_level),
    .best_vec(best_vec)
  );

  // Four frames hold four nesting depths; a request that would
  // overflow the stack is held back until a return frees a frame
  ipv_return_stack u_stack (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .push(take_vec),
    .push_frame({ack_pc, ack_srl, cpu_level}),
    .pop(do_pop),
    .top_frame(top_frame),
    .empty(stack_empty),
    .full(stack_full)
  );

  // ****************************************
  // Flags, enables and control
  // ****************************************
  // Set wins over a software clear in the same cycle; the vector
  // being taken leaves its flag alone so an unserviced source recurs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      source_flag_regs <= '0;
    end else begin
      source_flag_regs <= (source_flag_regs
        & ~(wr_flags ? reg_wdata[`IPV_NUM_USER-1:0] : '0))
        | src_event;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      source_enable_regs <= '0;
    end else if (reg_wr && reg_addr == `IPV_OFS_ENABLES) begin
      source_enable_regs <= reg_wdata[`IPV_NUM_USER-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trap_flag <= '0;
      nesting_disable <= 1'b0;
    end else begin
      trap_flag <= (trap_flag & ~(wr_ctrl ?
        reg_wdata[`IPV_TRAP_FLAG_LSB +: `IPV_NUM_TRAP] : '0))
        | trap_event;
      if (wr_ctrl) begin
        nesting_disable <= reg_wdata[`IPV_NEST_DIS_BIT];
      end
    end
  end

  // ****************************************
  // CPU level and unstacking
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_level <= 4'h0;
    end else if (take_vec) begin
      cpu_level <= irq_level;
    end else if (do_pop) begin
      cpu_level <= top_frame.level;
    end else if (reg_wr && reg_addr == `IPV_OFS_CPU_LEVEL
                 && !cpu_level[3]) begin
      // Software may not leave a trap level by a register write
      cpu_level <= {1'b0, reg_wdata[2:0]};
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ret_pc <= 16'h0000;
      ret_srl <= 8'h00;
      ret_valid <= 1'b0;
    end else begin
      ret_valid <= do_pop;
      if (do_pop) begin
        ret_pc <= top_frame.pc;
        ret_srl <= top_frame.status_low_byte;
      end
    end
  end

  // ****************************************
  // Timed interrupt block
  // ****************************************
  // A new op reloads the count, even when shorter than what is left
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timed_count <= '0;
    end else if (timed_interrupt_block_op) begin
      timed_count <= timed_block_cycles;
    end else if (timed_block_active) begin
      timed_count <= timed_count - 14'h0001;
    end
  end

  // ****************************************
  // Request to the CPU
  // ****************************************
  // Request drops on the acknowledge edge so the CPU never sees a
  // vector that was chosen against the old level
  // Level and vector follow the request, so the status word never
  // shows a stale vector while nothing is pending
  assign next_req = best_valid && !stack_full
    && !take_vec;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req <= 1'b0;
      irq_level <= 4'h0;
      irq_vector_index <= 7'h00;
    end else begin
      irq_req <= next_req;
      irq_level <= next_req ? best_level : 4'h0;
      irq_vector_index <= next_req ? best_vec : 7'h00;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  // Fields use the same stride as the writes, then are masked again
  always_comb begin
    uart_error_fault_priority = 16'h0000;
    can_tx_dma_priority = 16'h0000;
    for (int i = 0; i < `IPV_REG_A_FIELDS; i++) begin
      uart_error_fault_priority[`IPV_REG_A_TOP_LSB
        - `IPV_FIELD_STRIDE * i +: 3] = user_prio[i];
    end
    for (int i = `IPV_REG_A_FIELDS; i < `IPV_NUM_USER; i++) begin
      can_tx_dma_priority[`IPV_REG_B_TOP_LSB
        - `IPV_FIELD_STRIDE * (i - `IPV_REG_A_FIELDS) +: 3] = user_prio[i];
    end
    uart_error_fault_priority = uart_error_fault_priority
      & `IPV_PRIO_A_MASK;
    can_tx_dma_priority = can_tx_dma_priority & `IPV_PRIO_B_MASK;
    interrupt_level_vector_status = 16'h0000;
    interrupt_level_vector_status[`IPV_STAT_LEVEL_LSB +: 4] = irq_level;
    interrupt_level_vector_status[`IPV_STAT_VEC_LSB +: 7] =
      irq_vector_index;
    interrupt_control_one = 16'h0000;
    interrupt_control_one[`IPV_NEST_DIS_BIT] = nesting_disable;
    interrupt_control_one[`IPV_TRAP_FLAG_LSB +: `IPV_NUM_TRAP] = trap_flag;
  end

  always_comb begin
    case (reg_addr)
      `IPV_OFS_PRIO_A: next_rdata = uart_error_fault_priority;
      `IPV_OFS_PRIO_B: next_rdata = can_tx_dma_priority;
      `IPV_OFS_STATUS: next_rdata = interrupt_level_vector_status;
      `IPV_OFS_CTRL1: next_rdata = interrupt_control_one;
      `IPV_OFS_FLAGS: next_rdata = {9'h000, source_flag_regs};
      `IPV_OFS_ENABLES: next_rdata = {9'h000, source_enable_regs};
      `IPV_OFS_CPU_LEVEL: next_rdata = {12'h000, cpu_level};
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end
endmodule

// >>> ipv_controller_sva.sv
`timescale 1ns/10ps
`include "ipv_consts.svh"
module ipv_controller_sva
  import ipv_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic irq_req,
  input wire ipv_level_t irq_level,
  input wire ipv_vec_t irq_vector_index,
  input wire logic irq_ack,
  input wire logic return_from_interrupt_op,
  input wire logic ret_valid,
  input wire ipv_level_t cpu_level,
  input wire logic timed_interrupt_block_op,
  input wire logic [`IPV_TIMER_W-1:0] timed_block_cycles,
  input wire logic timed_block_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  AST_NO_REQ_ZERO: assert property (!irq_req |->
    irq_level == 4'h0 && irq_vector_index == 7'h00)
    else $error("status fields set without request");
  AST_ACK_DROP: assert property (irq_ack && irq_req |=> !irq_req)
    else $error("request held after ack");
  AST_ACK_LEVEL: assert property (irq_ack && irq_req |=>
    cpu_level == $past(irq_level))
    else $error("cpu level not taken from vector");
  AST_ABOVE_CPU: assert property (irq_req && irq_level < 4'h8 |->
    irq_level > $past(cpu_level))
    else $error("user request not above cpu level");
  AST_TRAP_VEC: assert property (irq_req && irq_level >= 4'h8 |->
    irq_vector_index == {3'h0, irq_level - 4'h8})
    else $error("trap vector wrong");
  AST_USER_VEC: assert property (irq_req && irq_level < 4'h8 |->
    irq_level != 4'h0 && irq_vector_index inside {[7'h10:7'h16]})
    else $error("user vector wrong");
  AST_TIMED_MASK: assert property ($past(timed_block_active) && irq_req
    |-> irq_level >= 4'h7)
    else $error("timed block let low level pass");
  AST_TIMED_START: assert property (timed_interrupt_block_op &&
    timed_block_cycles != 14'h0000 |=> timed_block_active)
    else $error("timed block not started");
  AST_RET_CAUSE: assert property (ret_valid |->
    $past(return_from_interrupt_op))
    else $error("return without return op");
endmodule
bind ipv_controller ipv_controller_sva ipv_controller_sva_i (
  .core_clk(core_clk), .arst_n(arst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_level(irq_level),
  .irq_vector_index(irq_vector_index), .irq_ack(irq_ack),
  .return_from_interrupt_op(return_from_interrupt_op),
  .ret_valid(ret_valid), .cpu_level(cpu_level),
  .timed_interrupt_block_op(timed_interrupt_block_op),
  .timed_block_cycles(timed_block_cycles),
  .timed_block_active(timed_block_active));

// >>> ipv_cpu_model.sv
`timescale 1ns/10ps
module ipv_cpu_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic [3:0] svc_len,
  input wire logic irq_req,
  output logic irq_ack,
  output logic [15:0] ack_pc,
  output logic [7:0] ack_srl,
  output logic ret_op
);
  logic [7:0] n_ack;
  logic [3:0] cnt;
  // Stacked values change per vector so a stale frame shows up
  assign ack_pc = {8'h12, n_ack};
  assign ack_srl = ~n_ack;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ack <= 1'b0;
      n_ack <= 8'h00;
      cnt <= 4'h0;
      ret_op <= 1'b0;
    end else begin
      irq_ack <= en && irq_req && !irq_ack;
      ret_op <= (cnt == 4'h1);
      if (irq_ack && irq_req) begin
        n_ack <= n_ack + 8'h01;
        cnt <= svc_len;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// >>> ipv_pkg.sv
package ipv_pkg;
  typedef logic [3:0] ipv_level_t;
  typedef logic [2:0] ipv_prio_t;
  typedef logic [6:0] ipv_vec_t;
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] status_low_byte;
    ipv_level_t level;
  } ipv_frame_t;
endpackage

// >>> ipv_return_stack.sv
`timescale 1ns/10ps
`include "ipv_consts.svh"
module ipv_return_stack
  import ipv_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic push,
  input wire ipv_frame_t push_frame,
  input wire logic pop,
  output ipv_frame_t top_frame,
  output logic empty,
  output logic full
);
  ipv_frame_t mem [`IPV_STACK_DEPTH];
  logic [`IPV_STACK_PTR_W-1:0] count;

  assign empty = (count == 3'h0);
  assign full = (count == 3'(`IPV_STACK_DEPTH));
  assign top_frame = empty ? '0 : mem[2'(count - 3'h1)];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 3'h0;
    end else if (push && !full) begin
      count <= count + 3'h1;
    end else if (pop && !empty) begin
      count <= count - 3'h1;
    end
  end

  for (genvar g = 0; g < `IPV_STACK_DEPTH; g++) begin : g_entry
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        mem[g] <= '0;
      end else if (push && !full && count == 3'(g)) begin
        mem[g] <= push_frame;
      end
    end
  end
endmodule

// >>> testbench.sv
`timescale 1ns/10ps
`include "ipv_consts.svh"
module testbench
  import ipv_pkg::*;
;
  logic core_clk, arst_n, reg_wr, reg_rd, irq_req, irq_ack, ret_op;
  logic ret_valid, tb_op, blk, cpu_en;
  logic [3:0] reg_addr, svc_len, trap_event;
  logic [6:0] src_event;
  logic [7:0] ack_srl, ret_srl;
  logic [15:0] reg_wdata, reg_rdata, ack_pc, ret_pc;
  logic [13:0] tb_cyc;
  ipv_level_t irq_level, cpu_level;
  ipv_vec_t irq_vector_index;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  ipv_controller ipv_controller_i (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .trap_event(trap_event), .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector_index(irq_vector_index), .irq_ack(irq_ack),
    .ack_pc(ack_pc), .ack_srl(ack_srl), .return_from_interrupt_op(ret_op),
    .ret_pc(ret_pc), .ret_srl(ret_srl), .ret_valid(ret_valid),
    .cpu_level(cpu_level), .timed_interrupt_block_op(tb_op),
    .timed_block_cycles(tb_cyc), .timed_block_active(blk));
  ipv_cpu_model ipv_cpu_model_i (.core_clk(core_clk), .arst_n(arst_n),
    .en(cpu_en), .svc_len(svc_len), .irq_req(irq_req), .irq_ack(irq_ack),
    .ack_pc(ack_pc), .ack_srl(ack_srl), .ret_op(ret_op));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Scenarios take a few hundred cycles; far above that means a hang
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count = err_count + 1;
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask
  task automatic ev(input logic [6:0] s, input logic [3:0] t);
    @(posedge core_clk);
    src_event <= s;
    trap_event <= t;
    @(posedge core_clk);
    src_event <= 7'h00;
    trap_event <= 4'h0;
  endtask
  task automatic ci(input logic r, input ipv_level_t l, input ipv_vec_t v);
    tk(2);
    chk("irq", {4'h0, r, l, v}, {4'h0, irq_req, irq_level, irq_vector_index});
  endtask
  task automatic s_regs();
    rd(`IPV_OFS_PRIO_A, 16'h0444);
    rd(`IPV_OFS_PRIO_B, 16'h4444);
    wr(`IPV_OFS_PRIO_A, 16'hFFFF);
    rd(`IPV_OFS_PRIO_A, 16'h0777);
    wr(`IPV_OFS_PRIO_B, 16'hFFFF);
    rd(`IPV_OFS_PRIO_B, 16'h7777);
    wr(`IPV_OFS_STATUS, 16'hFFFF);
    rd(`IPV_OFS_STATUS, 16'h0000);
    rd(4'hF, 16'h0000);
    $display("test regs done");
  endtask
  task automatic s_arb();
    wr(`IPV_OFS_ENABLES, 16'h007F);
    wr(`IPV_OFS_PRIO_A, 16'h0123);
    wr(`IPV_OFS_PRIO_B, 16'h0000);
    ev(7'h7F, 4'h0);
    ci(1'b1, 4'h3, 7'h12);
    rd(`IPV_OFS_STATUS, 16'h0312);
    wr(`IPV_OFS_PRIO_B, 16'h3000);
    ci(1'b1, 4'h3, 7'h12);
    wr(`IPV_OFS_PRIO_B, 16'h0450);
    ci(1'b1, 4'h5, 7'h15);
    wr(`IPV_OFS_CPU_LEVEL, 16'h0005);
    ci(1'b0, 4'h0, 7'h00);
    wr(`IPV_OFS_CPU_LEVEL, 16'h0000);
    wr(`IPV_OFS_ENABLES, 16'h0000);
    ci(1'b0, 4'h0, 7'h00);
    wr(`IPV_OFS_FLAGS, 16'h007F);
    rd(`IPV_OFS_FLAGS, 16'h0000);
    $display("test arbitration done");
  endtask
  task automatic s_svc();
    wr(`IPV_OFS_PRIO_A, 16'h0400);
    wr(`IPV_OFS_PRIO_B, 16'h0000);
    wr(`IPV_OFS_ENABLES, 16'h0001);
    cpu_en <= 1'b1;
    ev(7'h01, 4'h0);
    for (int i = 0; i < 60 && irq_ack !== 1'b1; i++) tk(1);
    tk(1);
    chk("cpu_level", 16'h0004, {12'h000, cpu_level});
    for (int i = 0; i < 60 && ret_valid !== 1'b1; i++) tk(1);
    chk("ret_valid", 16'h0001, {15'h0000, ret_valid});
    chk("ret_pc", 16'h1200, ret_pc);
    chk("ret_srl", 16'h00FF, {8'h00, ret_srl});
    chk("cpu_level", 16'h0000, {12'h000, cpu_level});
    for (int i = 0; i < 60 && irq_ack !== 1'b1; i++) tk(1);
    chk("reentry", 16'h0001, {15'h0000, irq_ack});
    cpu_en <= 1'b0;
    wr(`IPV_OFS_FLAGS, 16'h0001);
    tk(20);
    ci(1'b0, 4'h0, 7'h00);
    $display("test service done");
  endtask
  task automatic s_trap();
    wr(`IPV_OFS_CPU_LEVEL, 16'h0007);
    wr(`IPV_OFS_PRIO_A, 16'h0700);
    ev(7'h01, 4'h0);
    ci(1'b0, 4'h0, 7'h00);
    ev(7'h00, 4'h2);
    ci(1'b1, 4'h9, 7'h01);
    rd(`IPV_OFS_CTRL1, 16'h0002);
    wr(`IPV_OFS_CTRL1, 16'h0002);
    ci(1'b0, 4'h0, 7'h00);
    wr(`IPV_OFS_CPU_LEVEL, 16'h0000);
    ci(1'b1, 4'h7, 7'h10);
    wr(`IPV_OFS_FLAGS, 16'h007F);
    $display("test trap done");
  endtask
  task automatic s_timed();
    wr(`IPV_OFS_PRIO_A, 16'h0607);
    wr(`IPV_OFS_ENABLES, 16'h0005);
    @(posedge core_clk);
    tb_op <= 1'b1;
    tb_cyc <= 14'h0020;
    @(posedge core_clk);
    tb_op <= 1'b0;
    ev(7'h01, 4'h0);
    ci(1'b0, 4'h0, 7'h00);
    chk("blk", 16'h0001, {15'h0000, blk});
    ev(7'h04, 4'h0);
    ci(1'b1, 4'h7, 7'h12);
    wr(`IPV_OFS_FLAGS, 16'h0004);
    for (int i = 0; i < 60 && blk !== 1'b0; i++) tk(1);
    chk("blk", 16'h0000, {15'h0000, blk});
    ci(1'b1, 4'h6, 7'h10);
    wr(`IPV_OFS_FLAGS, 16'h007F);
    $display("test timed block done");
  endtask
  task automatic s_nest();
    wr(`IPV_OFS_CTRL1, 16'h8000);
    wr(`IPV_OFS_PRIO_A, 16'h0207);
    svc_len <= 4'hF;
    cpu_en <= 1'b1;
    ev(7'h01, 4'h0);
    for (int i = 0; i < 60 && irq_ack !== 1'b1; i++) tk(1);
    cpu_en <= 1'b0;
    ev(7'h04, 4'h0);
    ci(1'b0, 4'h0, 7'h00);
    wr(`IPV_OFS_CTRL1, 16'h0000);
    ci(1'b1, 4'h7, 7'h12);
    $display("test nesting done");
  endtask
  initial begin
    arst_n = 1'b0;
    {reg_wr, reg_rd, tb_op, cpu_en} = 4'h0;
    {reg_addr, trap_event} = 8'h00;
    reg_wdata = 16'h0000;
    src_event = 7'h00;
    tb_cyc = 14'h0000;
    svc_len = 4'h4;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    s_regs();
    s_arb();
    s_svc();
    s_trap();
    s_timed();
    s_nest();
    stop_test();
  end
endmodule
